// >>> core/engine_speed_plausibility_monitor.sv
`timescale 1ns/10ps
`include "speed_monitor_consts.svh"
// Summary of operation
// - check runs only while the calibration enable bit is set
// - check runs only while measured engine speed exceeds 600 rpm
// - check runs only with shift complete and range not neutral
// - large change held at or above 600 rpm for 0.15 s sets fault
// - low counter steps after 80 samples with change below 650 rpm
// - high counter steps on each sampled change above 1050 rpm
// - noise fault once both counters reach 5 events
// - fault becoming active logs the fault code into history
// - warning lamp stays off for this fault
// - while fault active, turbine speed replaces engine speed
// - service tool clear removes the logged fault code
// - 40 clean warm-up cycles in a row erase the logged code
// - engine speed derived from sensor pulse frequency
module engine_speed_plausibility_monitor
  import speed_monitor_pkg::*;
#(
  parameter int          SAMPLE_CYCLES  = int'(`SAMPLE_TIME_S * `CLK_HZ),
  parameter int          PERSIST_CYCLES = int'(`PERSIST_TIME_S * `CLK_HZ),
  parameter int          TEETH          = 12,
  parameter logic [15:0] FAULT_CODE_ID  = 16'h0001  // arbitrary value
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  // register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output      logic [31:0] rdata,
  // sensor and drivetrain state
  input  wire logic        sensor_pulse,
  input  wire rpm_t        turbine_speed,
  input  wire logic        shift_done,
  input  wire logic        range_neutral,
  input  wire logic        warmup_done,
  // results
  output      rpm_t        engine_speed_out,
  output      logic        fault_active,
  output      logic        history_valid,
  output      logic [15:0] speed_plausibility_fault_code,
  output      logic        transmission_warning_lamp,
  output      logic        irq
);

  // rpm per counted pulse in one sample gate
  localparam int SCALE_INT = int'(60.0 / (`SAMPLE_TIME_S * TEETH));
  localparam rpm_t SCALE = rpm_t'(SCALE_INT);

  // refuse parameter values the counters cannot serve
  if (SAMPLE_CYCLES < 2 || PERSIST_CYCLES < 1 || TEETH < 1 || SCALE_INT < 1) begin : g_bad_param
    $error("engine_speed_plausibility_monitor: bad parameters");
  end

  logic [31:0] tick_cnt_reg;
  logic        tick;
  logic        pulse_d_reg;
  logic [7:0]  edge_cnt_reg;
  rpm_t        speed_reg;
  rpm_t        prev_speed_reg;
  logic        have_prev_reg;
  rpm_t        delta;
  logic        run_ok;
  logic        check_en_reg;
  logic [6:0]  window_reg;
  logic [2:0]  low_cnt_reg;
  logic [2:0]  high_cnt_reg;
  logic        large_pend_reg;
  logic [31:0] persist_reg;
  logic        persist_hit;
  logic        noise_hit;
  logic        fail_now;
  logic        active_reg;
  logic        history_reg;
  logic        failed_cycle_reg;
  logic [5:0]  warm_cnt_reg;
  logic        auto_clear;
  logic        tool_clear;
  logic [2:0]  irq_status_reg;
  logic [2:0]  irq_enable_reg;
  logic [2:0]  irq_set;
  logic [31:0] rdata_reg;
  logic        low_step;
  logic        high_step;

  // sample tick divider
  // periodic sample tick
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tick_cnt_reg <= 32'h0;
    end else if (tick) begin
      tick_cnt_reg <= 32'h0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h1;
    end
  end
  assign tick = (tick_cnt_reg == 32'(SAMPLE_CYCLES - 1));

  // pulse edge counting within each gate
  // frequency by counting
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pulse_d_reg  <= 1'b0;
      edge_cnt_reg <= 8'h0;
    end else begin
      pulse_d_reg <= sensor_pulse;
      if (tick) begin
        edge_cnt_reg <= {7'h0, sensor_pulse && !pulse_d_reg};  // tick-cycle edge opens next gate
      end else if (sensor_pulse && !pulse_d_reg && edge_cnt_reg != 8'hff) begin
        edge_cnt_reg <= edge_cnt_reg + 8'h1;  // saturates
      end
    end
  end

  // convert count to rpm and keep previous sample
  // count to speed
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      speed_reg      <= 16'h0;
      prev_speed_reg <= 16'h0;
      have_prev_reg  <= 1'b0;
    end else if (tick) begin
      speed_reg      <= rpm_t'({8'h0, edge_cnt_reg} * SCALE);
      prev_speed_reg <= speed_reg;
      have_prev_reg  <= 1'b1;
    end
  end

  assign delta = (speed_reg >= prev_speed_reg) ? speed_reg - prev_speed_reg
                                               : prev_speed_reg - speed_reg;

  // run gate
  // calibration enable
  assign run_ok = check_en_reg && (speed_reg > `RUN_MIN_RPM) && shift_done
                  && !range_neutral && have_prev_reg;

  assign low_step  = tick && run_ok && (delta < `LOW_NOISE_RPM)
                     && (window_reg == `LOW_WINDOW_SAMPLES - 7'd1);
  assign high_step = tick && run_ok && (delta > `HIGH_NOISE_RPM);

  // low noise sample window
  // cleared outside run
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      window_reg <= 7'h0;
    end else if (!run_ok || fail_now) begin
      window_reg <= 7'h0;
    end else if (tick) begin
      if (delta >= `LOW_NOISE_RPM || low_step) begin
        window_reg <= 7'h0;
      end else begin
        window_reg <= window_reg + 7'h1;
      end
    end
  end

  // noise event counters, saturating at the trip count
  // cleared outside run
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      low_cnt_reg  <= 3'h0;
      high_cnt_reg <= 3'h0;
    end else if (!run_ok || fail_now) begin
      low_cnt_reg  <= 3'h0;
      high_cnt_reg <= 3'h0;
    end else begin
      if (low_step && low_cnt_reg != `NOISE_EVENTS) begin
        low_cnt_reg <= low_cnt_reg + 3'h1;
      end
      if (high_step && high_cnt_reg != `NOISE_EVENTS) begin
        high_cnt_reg <= high_cnt_reg + 3'h1;
      end
    end
  end

  assign noise_hit = (low_cnt_reg == `NOISE_EVENTS) && (high_cnt_reg == `NOISE_EVENTS);

  // large change persistence timer
  // cleared outside run
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      large_pend_reg <= 1'b0;
      persist_reg    <= 32'h0;
    end else if (!run_ok || fail_now) begin
      large_pend_reg <= 1'b0;
      persist_reg    <= 32'h0;
    end else begin
      // pending while each sample shows a large change
      if (tick) begin
        large_pend_reg <= (delta > `HIGH_NOISE_RPM) && (speed_reg >= `RUN_MIN_RPM);
      end
      if (!large_pend_reg) begin
        persist_reg <= 32'h0;
      end else if (!persist_hit) begin
        persist_reg <= persist_reg + 32'h1;
      end
    end
  end

  assign persist_hit = large_pend_reg && (persist_reg == 32'(PERSIST_CYCLES - 1));
  assign fail_now    = run_ok && (persist_hit || noise_hit);

  // tool clear command from the register port
  // service tool clear
  assign tool_clear = wr && (addr == `OFS_CMD) && wdata[`CMD_TOOL_CLEAR_BIT];

  // warm-up cycle tracking
  // consecutive clean warm-ups
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      warm_cnt_reg     <= 6'h0;
      failed_cycle_reg <= 1'b0;
    end else if (tool_clear || auto_clear) begin
      warm_cnt_reg     <= 6'h0;
      failed_cycle_reg <= fail_now;
    end else if (warmup_done) begin
      failed_cycle_reg <= fail_now;
      if (failed_cycle_reg || fail_now || !history_reg) begin
        warm_cnt_reg <= 6'h0;
      end else begin
        warm_cnt_reg <= warm_cnt_reg + 6'h1;
      end
    end else if (fail_now) begin
      failed_cycle_reg <= 1'b1;
    end
  end
  assign auto_clear = warmup_done && history_reg && !failed_cycle_reg && !fail_now
                      && (warm_cnt_reg == `WARMUP_CLEAR - 6'd1);

  // fault active and history store, set wins over clear
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      active_reg  <= 1'b0;
      history_reg <= 1'b0;
    end else if (fail_now) begin
      active_reg  <= 1'b1;
      history_reg <= 1'b1;
    end else if (tool_clear || auto_clear) begin
      active_reg  <= 1'b0;
      history_reg <= 1'b0;
    end
  end

  // substituted speed and logged code outputs
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      engine_speed_out              <= 16'h0;
      speed_plausibility_fault_code <= 16'h0;
    end else begin
      engine_speed_out              <= active_reg ? turbine_speed : speed_reg;
      speed_plausibility_fault_code <= history_reg ? FAULT_CODE_ID : 16'h0;
    end
  end

  assign fault_active  = active_reg;
  assign history_valid = history_reg;
  assign transmission_warning_lamp = 1'b0;

  // control register
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      check_en_reg <= `CTRL_RESET;
    end else if (wr && addr == `OFS_CTRL) begin
      check_en_reg <= wdata[`CTRL_CHECK_EN_BIT];
    end
  end

  // interrupt events
  always_comb begin
    irq_set                 = 3'h0;
    irq_set[IRQ_FAULT_SET]  = fail_now && !active_reg;
    irq_set[IRQ_AUTO_CLEAR] = auto_clear;
    irq_set[IRQ_NOISE]      = low_step || high_step;
  end

  // sticky status, set wins over write-one-to-clear
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      irq_status_reg <= 3'h0;
      irq_enable_reg <= `IRQ_ENABLE_RESET;
    end else begin
      if (wr && addr == `OFS_IRQ_CLEAR) begin
        irq_status_reg <= (irq_status_reg & ~wdata[2:0]) | irq_set;
      end else begin
        irq_status_reg <= irq_status_reg | irq_set;
      end
      if (wr && addr == `OFS_IRQ_ENABLE) begin
        irq_enable_reg <= wdata[2:0];
      end
    end
  end
  assign irq = |(irq_status_reg & irq_enable_reg);

  // read data, one cycle after the strobe
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdata_reg <= 32'h0;
    end else if (rd) begin
      rdata_reg <= 32'h0;
      case (addr)
        `OFS_CTRL:       rdata_reg[`CTRL_CHECK_EN_BIT] <= check_en_reg;
        `OFS_STATUS: begin
          rdata_reg[`ST_ACTIVE_BIT]              <= active_reg;
          rdata_reg[`ST_HISTORY_BIT]             <= history_reg;
          rdata_reg[`ST_RUN_BIT]                 <= run_ok;
          rdata_reg[`ST_LOW_LSB +: 3]            <= low_cnt_reg;
          rdata_reg[`ST_HIGH_LSB +: 3]           <= high_cnt_reg;
          rdata_reg[`ST_WARM_LSB +: 6]           <= warm_cnt_reg;
        end
        `OFS_SPEED:      rdata_reg[15:0] <= speed_reg;
        `OFS_IRQ_STATUS: rdata_reg[2:0] <= irq_status_reg;
        `OFS_IRQ_ENABLE: rdata_reg[2:0] <= irq_enable_reg;
        default:         rdata_reg <= 32'h0;  // unmapped and write-only read zero
      endcase
    end
  end
  assign rdata = rdata_reg;

endmodule : engine_speed_plausibility_monitor

// >>> core/speed_monitor_consts.svh
`ifndef SPEED_MONITOR_CONSTS_SVH
`define SPEED_MONITOR_CONSTS_SVH

// clock rate
`define CLK_HZ              10000000
// run window and thresholds, engine rpm
`define RUN_MIN_RPM         16'd600
`define LOW_NOISE_RPM       16'd650
`define HIGH_NOISE_RPM      16'd1050
// noise accounting
`define LOW_WINDOW_SAMPLES  7'd80
`define NOISE_EVENTS        3'd5
// persistence of a large change, seconds
`define PERSIST_TIME_S      0.15
// speed sampling gate, seconds
`define SAMPLE_TIME_S       0.05
// warm-up cycles that erase the logged code
`define WARMUP_CLEAR        6'd40
// register offsets
`define OFS_CTRL            8'h00
`define OFS_CMD             8'h04
`define OFS_STATUS          8'h08
`define OFS_SPEED           8'h0c
`define OFS_IRQ_STATUS      8'h10
`define OFS_IRQ_CLEAR       8'h14
`define OFS_IRQ_ENABLE      8'h18
// field positions
`define CTRL_CHECK_EN_BIT   0
`define CMD_TOOL_CLEAR_BIT  0
`define ST_ACTIVE_BIT       0
`define ST_HISTORY_BIT      1
`define ST_RUN_BIT          2
`define ST_LOW_LSB          4
`define ST_HIGH_LSB         8
`define ST_WARM_LSB         16
// reset values
`define CTRL_RESET          1'b1
`define IRQ_ENABLE_RESET    3'h0

`endif

// >>> core/speed_monitor_pkg.sv
package speed_monitor_pkg;

  // engine or turbine speed in rpm
  typedef logic [15:0] rpm_t;

  // interrupt status bit positions
  typedef enum logic [1:0] {
    IRQ_FAULT_SET  = 2'b00,
    IRQ_AUTO_CLEAR = 2'b01,
    IRQ_NOISE      = 2'b10
  } irq_bit_t;

endpackage : speed_monitor_pkg

// >>> verification/speed_monitor_sva.sv
`timescale 1ns/10ps
module speed_monitor_sva
  import speed_monitor_pkg::*;
#(
  parameter logic [15:0] FAULT_CODE_ID = 16'h0001
) (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        nrst,
  // register port
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  // drivetrain
  input wire rpm_t        turbine_speed,
  input wire logic        range_neutral,
  input wire logic        shift_done,
  // results
  input wire rpm_t        engine_speed_out,
  input wire logic        fault_active,
  input wire logic        history_valid,
  input wire logic [15:0] speed_plausibility_fault_code,
  input wire logic        transmission_warning_lamp
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  property p_lamp_off; transmission_warning_lamp == 1'b0; endproperty
  property p_subst;
    fault_active ##1 fault_active |-> engine_speed_out == $past(turbine_speed);
  endproperty
  property p_logged; fault_active |-> history_valid; endproperty
  property p_code;
    history_valid ##1 history_valid |-> speed_plausibility_fault_code == FAULT_CODE_ID;
  endproperty
  property p_code_gone;
    !history_valid ##1 !history_valid |-> speed_plausibility_fault_code == 16'h0000;
  endproperty
  // with the shift open no fail can win over the clear
  property p_tool_clear;
    wr && addr == 8'h04 && wdata[0] && !shift_done |=> !history_valid && !fault_active;
  endproperty
  property p_neutral;
    range_neutral && $past(range_neutral) && !fault_active |=> !fault_active;
  endproperty
  property p_unmapped; rd && addr == 8'h1c |=> rdata == 32'h0; endproperty
  a_lamp_off: assert property (p_lamp_off) else $error("lamp lit");
  a_subst: assert property (p_subst) else $error("no turbine substitute");
  a_logged: assert property (p_logged) else $error("active not logged");
  a_code: assert property (p_code) else $error("code missing");
  a_code_gone: assert property (p_code_gone) else $error("code stuck");
  a_tool_clear: assert property (p_tool_clear) else $error("clear ignored");
  a_neutral: assert property (p_neutral) else $error("fault in neutral");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  c_fault: cover property ($rose(fault_active));
  c_clear: cover property ($fell(history_valid));
  c_subst: cover property (fault_active ##1 fault_active);
endmodule : speed_monitor_sva

bind engine_speed_plausibility_monitor speed_monitor_sva #(.FAULT_CODE_ID(FAULT_CODE_ID)) u_sva (
  .clk_sys(clk_sys), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .turbine_speed(turbine_speed), .range_neutral(range_neutral),
  .shift_done(shift_done),
  .engine_speed_out(engine_speed_out), .fault_active(fault_active),
  .history_valid(history_valid),
  .speed_plausibility_fault_code(speed_plausibility_fault_code),
  .transmission_warning_lamp(transmission_warning_lamp)
);

// >>> verification/vr_sensor_model.sv
`timescale 1ns/10ps
module vr_sensor_model (
  // clock
  input  wire logic       clk_sys,
  // half period in clocks, zero stops the wheel
  input  wire logic [3:0] half,
  // digitised pickup
  output      logic       pulse
);
  logic [3:0] cnt_reg;
  // square wave; a period dividing the gate gives an exact edge count
  always_ff @(posedge clk_sys) begin
    if (half == 4'h0) begin
      pulse   <= 1'b0;
      cnt_reg <= 4'h0;
    end else if (cnt_reg >= half - 4'h1) begin
      pulse   <= ~pulse;
      cnt_reg <= 4'h0;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end
endmodule : vr_sensor_model

// >>> verification/engine_speed_plausibility_monitor_tb_top.sv
`timescale 1ns/10ps
module engine_speed_plausibility_monitor_tb_top;
  import speed_monitor_pkg::*;
  typedef struct packed {
    logic [3:0]  half;
    logic        sd;
    logic        neu;
    logic [15:0] rpm;
    logic        run;
  } row_t;
  logic clk_sys, nrst, wr, rd, shift_done, range_neutral, warmup_done, pulse;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] half;
  rpm_t turbine_speed, engine_speed_out;
  logic fault_active, history_valid, lamp, irq;
  logic [15:0] code;
  int n_errors, checks_done;
  // pickup half period, shift done, neutral, speed, run
  row_t rows [7] = '{'{4'h3, 1'b1, 1'b0, 16'h03e8, 1'b1}, '{4'h3, 1'b0, 1'b0, 16'h03e8, 1'b0},
    '{4'h3, 1'b1, 1'b1, 16'h03e8, 1'b0}, '{4'h6, 1'b1, 1'b0, 16'h01f4, 1'b0},
    '{4'h5, 1'b1, 1'b0, 16'h0258, 1'b0}, '{4'h2, 1'b1, 1'b0, 16'h05dc, 1'b1},
    '{4'h3, 1'b1, 1'b0, 16'h03e8, 1'b1}};

  engine_speed_plausibility_monitor #(.SAMPLE_CYCLES(60), .PERSIST_CYCLES(40)) dut (
    .clk_sys(clk_sys), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .sensor_pulse(pulse), .turbine_speed(turbine_speed),
    .shift_done(shift_done), .range_neutral(range_neutral), .warmup_done(warmup_done),
    .engine_speed_out(engine_speed_out), .fault_active(fault_active),
    .history_valid(history_valid), .speed_plausibility_fault_code(code),
    .transmission_warning_lamp(lamp), .irq(irq));
  vr_sensor_model sensor (.clk_sys(clk_sys), .half(half), .pulse(pulse));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    wr <= 1'b1; addr <= a; wdata <= v;
    @(posedge clk_sys);
    wr <= 1'b0;
    @(negedge clk_sys);
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk_sys);
    rd <= 1'b1; addr <= a;
    @(posedge clk_sys);
    rd <= 1'b0;
    @(negedge clk_sys);
    d = rdata;
  endtask : rd_reg
  task automatic gates(input int n);
    repeat (n * 60) @(posedge clk_sys);
  endtask : gates
  // alternate 1000 and 3000 rpm until the fault sets
  task automatic fault_up;
    for (int i = 0; i < 12; i++) begin
      half <= i[0] ? 4'h3 : 4'h1;
      gates(1);
      @(negedge clk_sys);
      if (fault_active === 1'b1) break;
    end
    half <= 4'h3;
    @(negedge clk_sys);
    chk("active", {31'h0, fault_active}, 32'h1);
  endtask : fault_up
  task automatic close_out;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    close_out();
  end
  initial begin
    nrst = 0; wr = 0; rd = 0; addr = 8'h00; wdata = 0; half = 4'h0; warmup_done = 0;
    turbine_speed = 16'h04d2; shift_done = 0; range_neutral = 0;
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    rd_reg(8'h00); chk("ctrl", d, 32'h1);
    rd_reg(8'h18); chk("irq_enable", d, 32'h0);
    rd_reg(8'h08); chk("status", d, 32'h0);
    rd_reg(8'h1c); chk("unmapped", d, 32'h0);
    foreach (rows[i]) begin
      @(posedge clk_sys);
      half <= rows[i].half; shift_done <= rows[i].sd; range_neutral <= rows[i].neu;
      gates(2);
      rd_reg(8'h0c); chk("speed", d, {16'h0, rows[i].rpm});
      chk("speed_out", {16'h0, engine_speed_out}, {16'h0, rows[i].rpm});
      rd_reg(8'h08); chk("run", {31'h0, d[2]}, {31'h0, rows[i].run});
    end
    wr_reg(8'h00, 32'h0); gates(2);
    rd_reg(8'h08); chk("run_off", {31'h0, d[2]}, 32'h0);
    wr_reg(8'h00, 32'h1); gates(85);
    rd_reg(8'h08); chk("noise_cnt", {25'h0, d[10:4]}, 32'h1);
    wr_reg(8'h18, 32'h1);
    fault_up();
    chk("history", {31'h0, history_valid}, 32'h1);
    chk("code", {16'h0, code}, 32'h1);
    chk("lamp", {31'h0, lamp}, 32'h0);
    chk("subst", {16'h0, engine_speed_out}, 32'h04d2);
    chk("irq", {31'h0, irq}, 32'h1);
    wr_reg(8'h14, 32'h1); chk("irq_clr", {31'h0, irq}, 32'h0);
    // open the shift so no late fail can meet the tool clear
    @(posedge clk_sys) shift_done <= 1'b0;
    wr_reg(8'h04, 32'h1); chk("tool_clr", {31'h0, history_valid}, 32'h0);
    chk("clr_active", {31'h0, fault_active}, 32'h0);
    @(negedge clk_sys); chk("code_clr", {16'h0, code}, 32'h0);
    @(posedge clk_sys) shift_done <= 1'b1;
    fault_up();
    // let the large changes die out before counting warm-ups
    gates(4);
    // first pulse closes the failed cycle, then 39 clean ones
    repeat (40) begin
      @(posedge clk_sys) warmup_done <= 1'b1;
      @(posedge clk_sys) warmup_done <= 1'b0;
    end
    @(negedge clk_sys); chk("warm39", {31'h0, history_valid}, 32'h1);
    @(posedge clk_sys) warmup_done <= 1'b1;
    @(posedge clk_sys) warmup_done <= 1'b0;
    @(negedge clk_sys); chk("warm40", {31'h0, history_valid}, 32'h0);
    chk("irq_again", {31'h0, irq}, 32'h1);
    wr_reg(8'h18, 32'h0); chk("irq_mask", {31'h0, irq}, 32'h0);
    close_out();
  end
endmodule : engine_speed_plausibility_monitor_tb_top
